// ### logic/dcf_defines.vh
// Purpose: Shared constants for the dual-clock FIFO with mailboxes.
// Assumes: Included by bare name from every design file.
// Notes:   Definitions only.
`ifndef DCF_DEFINES_VH
`define DCF_DEFINES_VH

// ----------------------------------------------------------------------------
// Storage geometry
// ----------------------------------------------------------------------------
`define DCF_DATA_W      36
`define DCF_ADDR_W      6
`define DCF_OFS_W       6
`define DCF_BYTE_W      9
`define DCF_BYTE_DATA_W 8
`define DCF_SKID_DEPTH  2

// ----------------------------------------------------------------------------
// Per-port control bundle layout (bit positions)
// ----------------------------------------------------------------------------
`define DCF_CTL_W       6
`define DCF_CTL_CLK     0
`define DCF_CTL_SEL_N   1
`define DCF_CTL_EN      2
`define DCF_CTL_WRITE   3
`define DCF_CTL_MBOX    4
`define DCF_CTL_PGEN    5

// ----------------------------------------------------------------------------
// Reset release: full flags open on this many write-port clock edges
// ----------------------------------------------------------------------------
`define DCF_INIT_W      2
`define DCF_INIT_DONE   2'h2
`define DCF_INIT_STEP   2'h1
`define DCF_INIT_ZERO   2'h0

`endif

// ### logic/dcf_skid.v
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock; in_ready low means both entries are full.
// Notes:   Never accepts a word it cannot hold.
`timescale 1ns/100ps
`default_nettype none
`include "dcf_defines.vh"

module dcf_skid #(
   parameter W = `DCF_DATA_W
) (
   input  wire         core_clk,
   input  wire         rst_n,
   input  wire         ce,
   input  wire         in_valid,
   output wire         in_ready,
   input  wire [W-1:0] in_data,
   output wire         out_valid,
   input  wire         out_ready,
   output wire [W-1:0] out_data
);

   reg [W-1:0] ent_r [0:`DCF_SKID_DEPTH-1];
   reg [1:0]   cnt_r;
   reg         wr_idx_r;
   reg         rd_idx_r;
   wire        push;
   wire        pop;

   assign in_ready  = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data  = ent_r[rd_idx_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r    <= 2'h0;
         wr_idx_r <= 1'b0;
         rd_idx_r <= 1'b0;
      end else if (ce) begin
         if (push) begin
            wr_idx_r <= ~wr_idx_r;
         end
         if (pop) begin
            rd_idx_r <= ~rd_idx_r;
         end
         if (push & ~pop) begin
            cnt_r <= cnt_r + 2'h1;
         end else if (pop & ~push) begin
            cnt_r <= cnt_r - 2'h1;
         end
      end
   end

   always @(posedge core_clk) begin
      if (ce & push) begin
         ent_r[wr_idx_r] <= in_data;
      end
   end

endmodule // dcf_skid
`default_nettype wire

// ### logic/dcf_gray_sync.v
// Purpose: Carries a pointer to the other port as Gray code through two stages.
// Assumes: dst_step pulses once per rising edge of the receiving port clock.
// Notes:   Only one bit changes per pointer step, so the receiver never sees a
//          torn value.
`timescale 1ns/100ps
`default_nettype none
`include "dcf_defines.vh"

module dcf_gray_sync #(
   parameter W = `DCF_ADDR_W + 1
) (
   input  wire         core_clk,
   input  wire         rst_n,
   input  wire         ce,
   input  wire [W-1:0] bin_in,
   input  wire         dst_step,
   output wire [W-1:0] bin_out
);

   reg  [W-1:0] gray_src_r;
   reg  [W-1:0] gray_s1_r;
   reg  [W-1:0] gray_s2_r;
   wire [W-1:0] bin_dec;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         gray_src_r <= {W{1'b0}};
         gray_s1_r  <= {W{1'b0}};
         gray_s2_r  <= {W{1'b0}};
      end else if (ce) begin
         gray_src_r <= bin_in ^ (bin_in >> 1);
         if (dst_step) begin
            gray_s1_r <= gray_src_r;
            gray_s2_r <= gray_s1_r;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Gray to binary
   // ----------------------------------------------------------------------------
   assign bin_dec[W-1] = gray_s2_r[W-1];
   genvar i;
   generate
      for (i = W - 2; i >= 0; i = i - 1) begin : g_dec
         assign bin_dec[i] = bin_dec[i+1] ^ gray_s2_r[i];
      end
   endgenerate
   assign bin_out = bin_dec;

endmodule // dcf_gray_sync
`default_nettype wire

// ### logic/dcf_fifo_mailbox.v
// Purpose: 64 x 36 FIFO from the write port to the read port, with one
//          mailbox each way, programmable almost flags and byte parity.
// Assumes: Both port clocks arrive as pins and are sampled on core_clk.
// Notes:   Port clock edges are found after a two-stage pin synchroniser.
`timescale 1ns/100ps
`default_nettype none
`include "dcf_defines.vh"

module dcf_fifo_mailbox #(
   parameter DATA_W = `DCF_DATA_W,
   parameter ADDR_W = `DCF_ADDR_W,
   parameter OFS_W  = `DCF_OFS_W
) (
   input  wire              core_clk,
   input  wire              rst_n,
   input  wire              ce,
   input  wire              write_port_clock,
   input  wire              wr_port_select_n,
   input  wire              wr_port_enable,
   input  wire              wr_port_write,
   input  wire              wr_port_mbox_sel,
   input  wire              wr_port_par_gen,
   input  wire [DATA_W-1:0] wr_port_data_in,
   output reg  [DATA_W-1:0] wr_port_data_out,
   output reg               wr_port_data_oe,
   input  wire              read_port_clock,
   input  wire              rd_port_select_n,
   input  wire              rd_port_enable,
   input  wire              rd_port_write,
   input  wire              rd_port_mbox_sel,
   input  wire              rd_port_par_gen,
   input  wire [DATA_W-1:0] rd_port_data_in,
   output reg  [DATA_W-1:0] rd_port_data_out,
   output reg               rd_port_data_oe,
   input  wire              parity_odd,
   input  wire [OFS_W-1:0]  almost_offset,
   output reg               full_n,
   output reg               almost_full_n,
   output reg               empty_n,
   output reg               almost_empty_n,
   output reg               fwd_mailbox_flag_n,
   output reg               rev_mailbox_flag_n,
   output reg  [DATA_W/`DCF_BYTE_W-1:0] wr_port_parity_err,
   output reg  [DATA_W/`DCF_BYTE_W-1:0] rd_port_parity_err
);

   localparam PTR_W  = ADDR_W + 1;
   localparam DEPTH  = 1 << ADDR_W;
   localparam BYTES  = DATA_W / `DCF_BYTE_W;
   localparam PORT_W = `DCF_CTL_W + DATA_W;
   localparam A_LO   = 0;
   localparam B_LO   = PORT_W;
   localparam ODD_P  = 2 * PORT_W;
   localparam OFS_LO = ODD_P + 1;
   localparam SW     = OFS_LO + OFS_W;
   localparam [SW-1:0] SYNC_RST = ({{(SW-1){1'b0}}, 1'b1} << (A_LO + `DCF_CTL_SEL_N))
                                | ({{(SW-1){1'b0}}, 1'b1} << (B_LO + `DCF_CTL_SEL_N));
   localparam [PTR_W-1:0] DEPTH_P = DEPTH[PTR_W-1:0];

   // ----------------------------------------------------------------------------
   // Pin synchroniser
   // ----------------------------------------------------------------------------
   reg  [SW-1:0] pin_s1_r;
   reg  [SW-1:0] pin_s2_r;
   reg           a_clk_d_r;
   reg           b_clk_d_r;
   wire [SW-1:0] pin_raw;

   assign pin_raw = {almost_offset, parity_odd,
                     rd_port_data_in, rd_port_par_gen, rd_port_mbox_sel, rd_port_write,
                     rd_port_enable, rd_port_select_n, read_port_clock,
                     wr_port_data_in, wr_port_par_gen, wr_port_mbox_sel, wr_port_write,
                     wr_port_enable, wr_port_select_n, write_port_clock};

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_r  <= SYNC_RST;
         pin_s2_r  <= SYNC_RST;
         a_clk_d_r <= 1'b0;
         b_clk_d_r <= 1'b0;
      end else if (ce) begin
         pin_s1_r  <= pin_raw;
         pin_s2_r  <= pin_s1_r;
         a_clk_d_r <= pin_s2_r[A_LO + `DCF_CTL_CLK];
         b_clk_d_r <= pin_s2_r[B_LO + `DCF_CTL_CLK];
      end
   end

   wire              a_sel_n = pin_s2_r[A_LO + `DCF_CTL_SEL_N];
   wire              a_en    = pin_s2_r[A_LO + `DCF_CTL_EN];
   wire              a_write = pin_s2_r[A_LO + `DCF_CTL_WRITE];
   wire              a_mbox  = pin_s2_r[A_LO + `DCF_CTL_MBOX];
   wire              a_pgen  = pin_s2_r[A_LO + `DCF_CTL_PGEN];
   wire [DATA_W-1:0] a_data  = pin_s2_r[A_LO + `DCF_CTL_W +: DATA_W];
   wire              b_sel_n = pin_s2_r[B_LO + `DCF_CTL_SEL_N];
   wire              b_en    = pin_s2_r[B_LO + `DCF_CTL_EN];
   wire              b_write = pin_s2_r[B_LO + `DCF_CTL_WRITE];
   wire              b_mbox  = pin_s2_r[B_LO + `DCF_CTL_MBOX];
   wire              b_pgen  = pin_s2_r[B_LO + `DCF_CTL_PGEN];
   wire [DATA_W-1:0] b_data  = pin_s2_r[B_LO + `DCF_CTL_W +: DATA_W];
   wire              odd     = pin_s2_r[ODD_P];
   wire [OFS_W-1:0]  ofs     = pin_s2_r[OFS_LO +: OFS_W];

   // ----------------------------------------------------------------------------
   // Qualified port events
   // ----------------------------------------------------------------------------
   wire a_edge = pin_s2_r[A_LO + `DCF_CTL_CLK] & ~a_clk_d_r;
   wire b_edge = pin_s2_r[B_LO + `DCF_CTL_CLK] & ~b_clk_d_r;
   wire a_go   = a_edge & ~a_sel_n & a_en;
   wire b_go   = b_edge & ~b_sel_n & b_en;
   wire buf_in_ready;
   wire a_wr_fifo = a_go & a_write & ~a_mbox & full_n & buf_in_ready;
   wire a_wr_mail = a_go & a_write & a_mbox & fwd_mailbox_flag_n;
   wire a_rd_mail = a_go & ~a_write & a_mbox;
   wire b_rd_fifo = b_go & ~b_write & ~b_mbox & empty_n;
   wire b_rd_mail = b_go & ~b_write & b_mbox;
   wire b_wr_mail = b_go & b_write & b_mbox & rev_mailbox_flag_n;

   // ----------------------------------------------------------------------------
   // Write path buffer and storage
   // ----------------------------------------------------------------------------
   reg  [DATA_W-1:0] mem [0:DEPTH-1];
   reg  [PTR_W-1:0]  wptr_r;
   reg  [PTR_W-1:0]  rptr_r;
   reg  [DATA_W-1:0] fifo_out_r;
   wire [PTR_W-1:0]  rptr_at_wr;
   wire [PTR_W-1:0]  wptr_at_rd;
   wire [DATA_W-1:0] buf_data;
   wire              buf_valid;
   wire [PTR_W-1:0]  wr_count = wptr_r - rptr_at_wr;
   wire [PTR_W-1:0]  wr_free  = DEPTH_P - wr_count;
   wire              mem_room = (wr_count != DEPTH_P);
   wire              drain    = buf_valid & mem_room;
   wire [PTR_W-1:0]  rptr_nxt = rptr_r + {{(PTR_W-1){1'b0}}, b_rd_fifo};
   wire [PTR_W-1:0]  rd_count = wptr_at_rd - rptr_nxt;

   dcf_skid #(
      .W (DATA_W)
   ) u_skid (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .in_valid  (a_wr_fifo),
      .in_ready  (buf_in_ready),
      .in_data   (a_data),
      .out_valid (buf_valid),
      .out_ready (mem_room),
      .out_data  (buf_data)
   );

   dcf_gray_sync #(
      .W (PTR_W)
   ) u_wptr_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .bin_in   (wptr_r),
      .dst_step (b_edge),
      .bin_out  (wptr_at_rd)
   );

   dcf_gray_sync #(
      .W (PTR_W)
   ) u_rptr_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .bin_in   (rptr_r),
      .dst_step (a_edge),
      .bin_out  (rptr_at_wr)
   );

   always @(posedge core_clk) begin
      if (ce & drain) begin
         mem[wptr_r[ADDR_W-1:0]] <= buf_data;
      end
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_r     <= {PTR_W{1'b0}};
         rptr_r     <= {PTR_W{1'b0}};
         fifo_out_r <= {DATA_W{1'b0}};
      end else if (ce) begin
         if (drain) begin
            wptr_r <= wptr_r + {{(PTR_W-1){1'b0}}, 1'b1};
         end
         if (b_rd_fifo) begin
            fifo_out_r <= mem[rptr_r[ADDR_W-1:0]];
         end
         rptr_r <= rptr_nxt;
      end
   end

   // ----------------------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------------------
   reg [`DCF_INIT_W-1:0] init_r;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         init_r         <= `DCF_INIT_ZERO;
         full_n         <= 1'b0;
         almost_full_n  <= 1'b0;
         empty_n        <= 1'b0;
         almost_empty_n <= 1'b0;
      end else if (ce) begin
         if (a_edge) begin
            if (init_r != `DCF_INIT_DONE) begin
               init_r <= init_r + `DCF_INIT_STEP;
            end
            full_n        <= (init_r != `DCF_INIT_ZERO) & (wr_count != DEPTH_P);
            almost_full_n <= (init_r != `DCF_INIT_ZERO) &
                             (wr_free > {1'b0, ofs});
         end
         if (b_edge) begin
            empty_n        <= (rd_count != {PTR_W{1'b0}});
            almost_empty_n <= (rd_count > {1'b0, ofs});
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Mailboxes
   // ----------------------------------------------------------------------------
   reg [DATA_W-1:0] mail_fwd_r;
   reg [DATA_W-1:0] mail_rev_r;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mail_fwd_r         <= {DATA_W{1'b0}};
         mail_rev_r         <= {DATA_W{1'b0}};
         fwd_mailbox_flag_n <= 1'b1;
         rev_mailbox_flag_n <= 1'b1;
      end else if (ce) begin
         if (a_wr_mail) begin
            mail_fwd_r         <= a_data;
            fwd_mailbox_flag_n <= 1'b0;
         end else if (b_rd_mail) begin
            fwd_mailbox_flag_n <= 1'b1;
         end
         if (b_wr_mail) begin
            mail_rev_r         <= b_data;
            rev_mailbox_flag_n <= 1'b0;
         end else if (a_rd_mail) begin
            rev_mailbox_flag_n <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Parity check and generation per byte lane
   // ----------------------------------------------------------------------------
   wire [DATA_W-1:0] b_src = b_mbox ? mail_fwd_r : fifo_out_r;
   wire [DATA_W-1:0] a_gen;
   wire [DATA_W-1:0] b_gen;
   wire [BYTES-1:0]  a_err;
   wire [BYTES-1:0]  b_err;

   genvar k;
   generate
      for (k = 0; k < BYTES; k = k + 1) begin : g_lane
         localparam LO = k * `DCF_BYTE_W;
         localparam PB = LO + `DCF_BYTE_DATA_W;
         assign a_err[k] = ^a_data[LO +: `DCF_BYTE_W] ^ odd;
         assign b_err[k] = ^b_data[LO +: `DCF_BYTE_W] ^ odd;
         assign a_gen[LO +: `DCF_BYTE_DATA_W] = mail_rev_r[LO +: `DCF_BYTE_DATA_W];
         assign a_gen[PB] = ^mail_rev_r[LO +: `DCF_BYTE_DATA_W] ^ odd;
         assign b_gen[LO +: `DCF_BYTE_DATA_W] = b_src[LO +: `DCF_BYTE_DATA_W];
         assign b_gen[PB] = ^b_src[LO +: `DCF_BYTE_DATA_W] ^ odd;
      end
   endgenerate

   // ----------------------------------------------------------------------------
   // Port data drivers and parity status
   // ----------------------------------------------------------------------------
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_port_data_out   <= {DATA_W{1'b0}};
         wr_port_data_oe    <= 1'b0;
         rd_port_data_out   <= {DATA_W{1'b0}};
         rd_port_data_oe    <= 1'b0;
         wr_port_parity_err <= {BYTES{1'b0}};
         rd_port_parity_err <= {BYTES{1'b0}};
      end else if (ce) begin
         wr_port_data_oe <= ~a_sel_n & ~a_write;
         rd_port_data_oe <= ~b_sel_n & ~b_write;
         if (a_go & ~a_write) begin
            wr_port_data_out <= a_pgen ? a_gen : mail_rev_r;
         end
         rd_port_data_out <= b_pgen ? b_gen : b_src;
         if (a_go & a_write) begin
            wr_port_parity_err <= a_err;
         end
         if (b_go & b_write) begin
            rd_port_parity_err <= b_err;
         end
      end
   end

endmodule // dcf_fifo_mailbox
`default_nettype wire

// ### verif/dcf_fifo_monitor.sv
// Purpose: Concurrent checks on the ports of the FIFO with mailboxes.
// Assumes: Port pins reach the logic two core cycles late.
// Notes:   Flag windows span four core cycles.
`timescale 1ns/100ps
`default_nettype none
`include "dcf_defines.vh"

module dcf_fifo_monitor #(
   parameter DATA_W = `DCF_DATA_W,
   parameter LANES  = DATA_W / `DCF_BYTE_W
) (
   input wire logic              core_clk,
   input wire logic              rst_n,
   input wire logic              write_port_clock,
   input wire logic              wr_port_select_n,
   input wire logic              wr_port_enable,
   input wire logic              wr_port_write,
   input wire logic              wr_port_mbox_sel,
   input wire logic              wr_port_data_oe,
   input wire logic [LANES-1:0]  wr_port_parity_err,
   input wire logic              read_port_clock,
   input wire logic              rd_port_select_n,
   input wire logic              rd_port_enable,
   input wire logic              rd_port_write,
   input wire logic              rd_port_mbox_sel,
   input wire logic [DATA_W-1:0] rd_port_data_out,
   input wire logic              full_n,
   input wire logic              almost_full_n,
   input wire logic              empty_n,
   input wire logic              almost_empty_n,
   input wire logic              fwd_mailbox_flag_n,
   input wire logic              rev_mailbox_flag_n
);
   // ---
   // Port edge tracking
   // ---
   logic [2:0] a_s_r, b_s_r, a_w_r, b_w_r;
   logic [1:0] a_cnt_r;
   wire a_ev = a_s_r[1] & ~a_s_r[2];
   wire b_ev = b_s_r[1] & ~b_s_r[2];
   wire a_win = a_ev | (|a_w_r);
   wire b_win = b_ev | (|b_w_r);
   wire a_q = a_ev & ~wr_port_select_n & wr_port_enable & wr_port_mbox_sel;
   wire b_q = b_ev & ~rd_port_select_n & rd_port_enable;
   wire fwd_wr = a_q & wr_port_write;
   wire rev_rd = a_q & ~wr_port_write;
   wire fwd_rd = b_q & ~rd_port_write & rd_port_mbox_sel;
   wire rev_wr = b_q & rd_port_write & rd_port_mbox_sel;
   wire fifo_rd = b_q & ~rd_port_write & ~rd_port_mbox_sel;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         a_s_r <= 3'h0;
         b_s_r <= 3'h0;
         a_w_r <= 3'h0;
         b_w_r <= 3'h0;
         a_cnt_r <= 2'h0;
      end else begin
         a_s_r <= {a_s_r[1:0], write_port_clock};
         b_s_r <= {b_s_r[1:0], read_port_clock};
         a_w_r <= {a_w_r[1:0], a_ev};
         b_w_r <= {b_w_r[1:0], b_ev};
         if (a_ev && a_cnt_r != 2'h2) begin
            a_cnt_r <= a_cnt_r + 2'h1;
         end
      end
   end

   // ---
   // Properties
   // ---
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_fwd_post; fwd_wr && fwd_mailbox_flag_n; endsequence
   sequence s_fwd_take; fwd_rd && !fwd_wr; endsequence
   sequence s_rev_post; rev_wr && rev_mailbox_flag_n; endsequence
   sequence s_rev_take; rev_rd && !rev_wr; endsequence
   sequence s_empty_rd; fifo_rd && !empty_n; endsequence

   a_oe_select_off: assert property (wr_port_select_n [*4] |-> !wr_port_data_oe)
      else $error("port A data driven while deselected");
   a_full_held_reset: assert property (a_cnt_r < 2'h2 |-> !full_n && !almost_full_n)
      else $error("full flags open before second write edge");
   a_full_on_wr: assert property ($changed({full_n, almost_full_n}) |-> a_win)
      else $error("full flags moved without a write edge");
   a_empty_on_rd: assert property ($changed({empty_n, almost_empty_n}) |-> b_win)
      else $error("empty flags moved without a read edge");
   a_unqual_ignored: assert property (
      a_ev && (wr_port_select_n || !wr_port_enable)
      |=> ($stable(wr_port_parity_err) && !$fell(fwd_mailbox_flag_n)) [*3])
      else $error("port A edge acted while not qualified");
   a_fwd_mail_set: assert property (s_fwd_post |-> ##[1:3] !fwd_mailbox_flag_n)
      else $error("forward mail flag not lowered by write");
   a_fwd_mail_clear: assert property (s_fwd_take |-> ##[1:3] fwd_mailbox_flag_n)
      else $error("forward mail flag not raised by read");
   a_rev_mail_set: assert property (s_rev_post |-> ##[1:3] !rev_mailbox_flag_n)
      else $error("reverse mail flag not lowered by write");
   a_rev_mail_clear: assert property (s_rev_take |-> ##[1:3] rev_mailbox_flag_n)
      else $error("reverse mail flag not raised by read");
   a_empty_blocks_rd: assert property (s_empty_rd |=> $stable(rd_port_data_out) [*3])
      else $error("read data moved while empty");
endmodule // dcf_fifo_monitor

bind dcf_fifo_mailbox dcf_fifo_monitor #(.DATA_W(DATA_W)) u_dcf_fifo_monitor (.*);
`default_nettype wire

// ### verif/dcf_port_model.sv
// Purpose: Bus master on one port.
// Assumes: All pins change at core_clk falling edges.
// Notes:   The port clock stands still between transfers; released data inverts.
`timescale 1ns/100ps
`default_nettype none

module dcf_port_model (
   input  wire logic        core_clk,
   output var  logic        pclk,
   output var  logic        sel_n,
   output var  logic        en,
   output var  logic        wr,
   output var  logic        mbox,
   output var  logic        pgen,
   output var  logic [35:0] data
);
   initial begin
      pclk = 1'b0;
      sel_n = 1'b1;
      en = 1'b0;
      wr = 1'b0;
      mbox = 1'b0;
      pgen = 1'b0;
      data = 36'h0;
   end

   // Controls lead the port edge by two cycles.
   task automatic xfer(input logic s_n, input logic e, input logic w, input logic m,
                       input logic g, input logic [35:0] d);
      @(negedge core_clk);
      sel_n = s_n;
      en = e;
      wr = w;
      mbox = m;
      pgen = g;
      data = d;
      repeat (2) @(negedge core_clk);
      pclk = 1'b1;
      repeat (3) @(negedge core_clk);
      pclk = 1'b0;
      repeat (2) @(negedge core_clk);
      sel_n = 1'b1;
      en = 1'b0;
      data = ~d;
   endtask
endmodule // dcf_port_model
`default_nettype wire

// ### verif/tb.sv
// Purpose: Self-checking bench for the FIFO with mailboxes.
// Assumes: Offset of four; both ports driven by port models.
// Notes:   Pins resolve from the output enables.
`timescale 1ns/100ps
`default_nettype none

module tb;
   logic        core_clk, rst_n, parity_odd;
   logic [5:0]  almost_offset;
   logic        write_port_clock, wr_port_select_n, wr_port_enable, wr_port_write;
   logic        wr_port_mbox_sel, wr_port_par_gen, wr_port_data_oe;
   logic        read_port_clock, rd_port_select_n, rd_port_enable, rd_port_write;
   logic        rd_port_mbox_sel, rd_port_par_gen, rd_port_data_oe;
   logic [35:0] wr_port_data_in, wr_port_data_out, a_drv, bad;
   logic [35:0] rd_port_data_in, rd_port_data_out, b_drv;
   logic        full_n, almost_full_n, empty_n, almost_empty_n;
   logic        fwd_mailbox_flag_n, rev_mailbox_flag_n;
   logic [3:0]  wr_port_parity_err, rd_port_parity_err;
   int          miscompares, samples_checked;

   assign wr_port_data_in = wr_port_data_oe ? wr_port_data_out : a_drv;
   assign rd_port_data_in = rd_port_data_oe ? rd_port_data_out : b_drv;

   dcf_fifo_mailbox u_dcf_fifo_mailbox (
      .core_clk, .rst_n, .ce(1'b1), .write_port_clock, .wr_port_select_n, .wr_port_enable,
      .wr_port_write, .wr_port_mbox_sel, .wr_port_par_gen, .wr_port_data_in, .wr_port_data_out,
      .wr_port_data_oe, .read_port_clock, .rd_port_select_n, .rd_port_enable, .rd_port_write,
      .rd_port_mbox_sel, .rd_port_par_gen, .rd_port_data_in, .rd_port_data_out,
      .rd_port_data_oe, .parity_odd, .almost_offset, .full_n, .almost_full_n, .empty_n,
      .almost_empty_n, .fwd_mailbox_flag_n, .rev_mailbox_flag_n, .wr_port_parity_err,
      .rd_port_parity_err);
   dcf_port_model u_port_a (.core_clk, .pclk(write_port_clock), .sel_n(wr_port_select_n),
      .en(wr_port_enable), .wr(wr_port_write), .mbox(wr_port_mbox_sel),
      .pgen(wr_port_par_gen), .data(a_drv));
   dcf_port_model u_port_b (.core_clk, .pclk(read_port_clock), .sel_n(rd_port_select_n),
      .en(rd_port_enable), .wr(rd_port_write), .mbox(rd_port_mbox_sel),
      .pgen(rd_port_par_gen), .data(b_drv));

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // ---
   // Helpers
   // ---
   function automatic logic [35:0] regen(input logic [35:0] w, input logic odd);
      for (int k = 0; k < 4; k++)
         w[9*k+8] = ^w[9*k +: 8] ^ odd;
      return w;
   endfunction
   function automatic logic [35:0] mk(input logic [7:0] b);
      return regen({1'b0, b + 8'h3, 1'b0, b + 8'h2, 1'b0, b + 8'h1, 1'b0, b}, 1'b1);
   endfunction
   task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wa(input logic m, input logic [35:0] d);
      u_port_a.xfer(1'b0, 1'b1, 1'b1, m, 1'b0, d);
   endtask
   task automatic rb(input logic m, input logic g);
      u_port_b.xfer(1'b0, 1'b1, 1'b0, m, g, 36'h0);
   endtask
   task automatic tick_a(input int n);
      repeat (n) u_port_a.xfer(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 36'h0);
   endtask
   task automatic tick_b(input int n);
      repeat (n) u_port_b.xfer(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 36'h0);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge core_clk);
      miscompares++;
      $display("ERROR watchdog expired");
      results();
   end

   // ---
   // Main sequence
   // ---
   initial begin
      rst_n = 1'b0;
      parity_odd = 1'b1;
      almost_offset = 6'h04;
      bad = mk(8'h05) ^ 36'h0_0004_0000;
      repeat (4) @(negedge core_clk);
      rst_n = 1'b1;
      @(negedge core_clk);
      chk("reset flags", {full_n, almost_full_n, empty_n, almost_empty_n, fwd_mailbox_flag_n,
          rev_mailbox_flag_n, wr_port_data_oe, rd_port_data_oe, wr_port_parity_err,
          rd_port_parity_err}, 36'h0c00);
      chk("reset data", wr_port_data_out | rd_port_data_out, 36'h0);
      wa(1'b0, mk(8'hf0));
      chk("full one edge", {full_n, almost_full_n}, 2'h0);
      tick_a(1);
      chk("full two edges", {full_n, almost_full_n}, 2'h3);
      for (int i = 0; i < 64; i++) begin
         wa(1'b0, mk(i[7:0]));
         if (i == 0) begin
            tick_b(2);
            chk("empty two edges", empty_n, 1'b0);
            tick_b(1);
            chk("empty three edges", empty_n, 1'b1);
         end
         if (i == 3 || i == 4 || i == 58 || i == 59) begin
            tick_a(2);
            tick_b(3);
            chk("almost empty", almost_empty_n, i > 3);
            chk("almost full", almost_full_n, i < 59);
         end
      end
      tick_a(2);
      chk("full flags", {full_n, almost_full_n, wr_port_parity_err}, 6'h00);
      wa(1'b0, mk(8'hf8));
      for (int i = 0; i < 64; i++) begin
         rb(1'b0, 1'b0);
         chk("fifo word", rd_port_data_out, mk(i[7:0]));
      end
      tick_b(3);
      chk("empty drained", {empty_n, almost_empty_n}, 2'h0);
      rb(1'b0, 1'b0);
      chk("read while empty", rd_port_data_out, mk(8'h3f));
      tick_a(3);
      wa(1'b0, mk(8'h70));
      tick_b(3);
      fork
         wa(1'b0, mk(8'h71));
         rb(1'b0, 1'b0);
      join
      chk("same edge read", rd_port_data_out, mk(8'h70));
      tick_b(3);
      rb(1'b0, 1'b0);
      chk("same edge write", rd_port_data_out, mk(8'h71));
      u_port_a.xfer(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, mk(8'h01));
      u_port_a.xfer(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, mk(8'h02));
      chk("mail unqualified", fwd_mailbox_flag_n, 1'b1);
      wa(1'b1, bad);
      chk("mail set", {fwd_mailbox_flag_n, wr_port_parity_err}, 5'h04);
      wa(1'b1, mk(8'h06));
      rb(1'b1, 1'b0);
      chk("mail raw", rd_port_data_out, bad);
      chk("mail cleared", fwd_mailbox_flag_n, 1'b1);
      rb(1'b1, 1'b1);
      chk("mail odd parity", rd_port_data_out, regen(bad, 1'b1));
      parity_odd = 1'b0;
      rb(1'b1, 1'b1);
      chk("mail even parity", rd_port_data_out, regen(bad, 1'b0));
      u_port_b.xfer(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, mk(8'h09));
      chk("reverse set", rev_mailbox_flag_n, 1'b0);
      chk("reverse parity", rd_port_parity_err, 4'hf);
      u_port_a.xfer(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 36'h0);
      chk("reverse mail", wr_port_data_out, mk(8'h09));
      chk("reverse cleared", rev_mailbox_flag_n, 1'b1);
      results();
   end
endmodule // tb
`default_nettype wire
